/* File: core/emsd_defs.vh */
// register offsets, field positions, reset values and address limits of the memory select block
`ifndef EMSD_DEFS_VH
`define EMSD_DEFS_VH
`define EMSD_OFS_OVLAY      8'h00
`define EMSD_OFS_WAIT       8'h04
`define EMSD_OFS_SYSC       8'h08
`define EMSD_OFS_STAT       8'h0c
`define EMSD_OVL_EXT1       4'h1
`define EMSD_OVL_EXT2       4'h2
`define EMSD_CMS_PM         0
`define EMSD_CMS_DM         1
`define EMSD_CMS_BM         2
`define EMSD_CMS_IO         3
`define EMSD_COMPOSITE_SELECT_ENABLES_RST     4'hb
`define EMSD_BMS_DIS_BIT    4
`define EMSD_WAIT_MODE_BIT  15
`define EMSD_OVLAY_RST      8'h00
`define EMSD_WAIT_RST       20'h00000
`define EMSD_PM_OVL_BASE    14'h2000
`define EMSD_DM_OVL_TOP     14'h1fff
`define EMSD_MMR_BASE       14'h3fe0
`define EMSD_SP_PM          2'h0
`define EMSD_SP_DM          2'h1
`define EMSD_SP_IO          2'h2
`define EMSD_SP_BM          2'h3
`define EMSD_OCM_AW         7
`endif

/* File: core/emsd_ocm.v */
// on-chip memory with registered read data, one cycle per access
`timescale 1ns/10ps
module emsd_ocm (
  // clock
  input  wire        hclk,
  // access port
  input  wire        en,
  input  wire        we,
  input  wire [6:0]  addr,
  input  wire [23:0] wdata,
  output reg  [23:0] rdata_ff
);
  reg [23:0] mem [0:127];

  always @(posedge hclk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata_ff <= mem[addr];
    end
  end
endmodule

/* File: core/emsd_top.v */
// external memory select, overlay mapping and wait-state generation with an AHB-Lite slave
// Summary of operation
// - program overlay 1/2: 0x2000-0x3FFF goes external, A13 = overlay-1.
// - data overlay 1/2: 0x0000-0x1FFF goes external, A13 = overlay-1.
// - program space words are 24 bits wide.
// - data space words are 16 bits wide.
// - top 32 data locations are control registers, never external.
// - on-chip memory accesses finish in two cycles, control registers in one, with no waits.
// - external data accesses wait per data wait field and mode bit.
// - host mode drives only A0 externally.
// - host mode refuses external program memory accesses.
// - I/O space: 2048 16-bit words on low eleven address bits.
// - I/O space has four 512-word regions, each with its own wait field.
// - I/O waits up to 15 from three-bit field plus mode bit.
// - composite select asserts with each enabled individual select.
// - composite select shares select timing and bus-request release.
// - composite enables reset to 1 except the byte select enable.
// - byte select enabled after reset; software may disable it.
// - bits without a default need no particular reset value.
`timescale 1ns/10ps
`include "emsd_defs.vh"
module emsd_top (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata_ff,
  output reg         hreadyout_ff,
  output reg         hresp_ff,
  // core access request
  input  wire        core_req,
  input  wire [1:0]  core_space,
  input  wire [13:0] core_addr,
  input  wire        core_we,
  input  wire [23:0] core_wdata,
  output reg         core_ack_ff,
  output reg         core_refused_ff,
  output reg  [23:0] core_rdata_ff,
  output reg         core_busy_ff,
  // external memory pins
  output reg  [13:0] ext_addr_ff,
  output reg  [23:0] ext_dout_ff,
  output reg         ext_dout_oe_ff,
  input  wire [23:0] ext_din,
  output reg         ext_rd_n_ff,
  output reg         ext_wr_n_ff,
  output reg         program_mem_select_n_ff,
  output reg         data_mem_select_n_ff,
  output reg         byte_mem_select_n_ff,
  output reg         io_space_select_n_ff,
  output reg         composite_mem_select_n_ff,
  output reg         mem_ctrl_oe_ff,
  // bus request and mode pins
  input  wire        bus_req_n,
  output reg         bus_grant_n_ff,
  input  wire        host_mode_pin
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_EXT   = 2'd1;
  localparam ST_GRANT = 2'd2;

  // wait count: mode 0 gives n, mode 1 gives 2n+1 (max 15)
  function [3:0] wait_of;
    input [2:0] field;
    input       mode;
    begin
      wait_of = mode ? {field, 1'b1} : {1'b0, field};
    end
  endfunction

  // software registers
  reg  [7:0]  ovlay_ff;
  reg  [19:0] wait_ff;
  reg  [3:0]  composite_select_enables_ff;
  reg         bms_dis_ff;
  // ahb data phase
  reg         dph_wr_ff;
  reg  [7:0]  dph_addr_ff;
  // pin synchronisers
  reg  [1:0]  br_sync_ff;
  reg  [1:0]  hm_sync_ff;
  reg  [23:0] din_s1_ff;
  reg  [23:0] din_s2_ff;
  // access engine
  reg  [1:0]  state_ff;
  reg  [3:0]  wcnt_ff;
  reg  [1:0]  space_ff;
  reg         we_ff;
  reg         int_pend_ff;

  wire [3:0]  pm_ovl = ovlay_ff[3:0];
  wire [3:0]  dm_ovl = ovlay_ff[7:4];
  wire        br_act = ~br_sync_ff[1];
  wire        host_mode = hm_sync_ff[1];
  wire        wmode = wait_ff[`EMSD_WAIT_MODE_BIT];

  // ---------------- ahb-lite slave ----------------
  wire        ahb_go = hsel & htrans[1] & hready;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_ff    <= 1'b0;
      dph_addr_ff  <= 8'h00;
      hrdata_ff    <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      dph_wr_ff <= ahb_go & hwrite;
      if (ahb_go) begin
        dph_addr_ff <= haddr;
      end
      if (ahb_go & ~hwrite) begin
        case (haddr)
          `EMSD_OFS_OVLAY: hrdata_ff <= {24'h000000, ovlay_ff};
          `EMSD_OFS_WAIT:  hrdata_ff <= {12'h000, wait_ff};
          `EMSD_OFS_SYSC:  hrdata_ff <= {27'h0, bms_dis_ff, composite_select_enables_ff};
          `EMSD_OFS_STAT:  hrdata_ff <= {28'h0000000, host_mode, ~bus_grant_n_ff,
                                         core_busy_ff, core_refused_ff};
          default:         hrdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // register writes in the data phase; reserved bits are dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovlay_ff   <= `EMSD_OVLAY_RST;
      wait_ff    <= `EMSD_WAIT_RST;
      composite_select_enables_ff  <= `EMSD_COMPOSITE_SELECT_ENABLES_RST;
      bms_dis_ff <= 1'b0;
    end else if (dph_wr_ff) begin
      case (dph_addr_ff)
        `EMSD_OFS_OVLAY: ovlay_ff <= hwdata[7:0];
        `EMSD_OFS_WAIT:  wait_ff <= hwdata[19:0];
        `EMSD_OFS_SYSC: begin
          composite_select_enables_ff  <= hwdata[3:0];
          bms_dis_ff <= hwdata[`EMSD_BMS_DIS_BIT];
        end
        default: ;
      endcase
    end
  end

  // ---------------- pin synchronisers ----------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      br_sync_ff <= 2'b11;
      hm_sync_ff <= 2'b00;
      din_s1_ff  <= 24'h000000;
      din_s2_ff  <= 24'h000000;
    end else begin
      br_sync_ff <= {br_sync_ff[0], bus_req_n};
      hm_sync_ff <= {hm_sync_ff[0], host_mode_pin};
      din_s1_ff  <= ext_din;
      din_s2_ff  <= din_s1_ff;
    end
  end

  // ---------------- request decode ----------------
  reg        dec_ext;
  reg        dec_refuse;
  reg [13:0] dec_addr;
  reg [3:0]  dec_wait;
  reg [3:0]  dec_sel;

  always @* begin
    dec_ext    = 1'b0;
    dec_refuse = 1'b0;
    dec_addr   = 14'h0000;
    dec_wait   = 4'h0;
    dec_sel    = 4'h0;
    case (core_space)
      `EMSD_SP_PM: begin
        if (core_addr >= `EMSD_PM_OVL_BASE &&
            (pm_ovl == `EMSD_OVL_EXT1 || pm_ovl == `EMSD_OVL_EXT2)) begin
          if (host_mode) begin
            dec_refuse = 1'b1;
          end else begin
            dec_ext  = 1'b1;
            dec_addr = {pm_ovl[1], core_addr[12:0]};
            dec_sel[`EMSD_CMS_PM] = 1'b1;
            dec_wait = wait_of(wait_ff[14:12], wmode);
          end
        end
      end
      `EMSD_SP_DM: begin
        if (core_addr <= `EMSD_DM_OVL_TOP &&
            (dm_ovl == `EMSD_OVL_EXT1 || dm_ovl == `EMSD_OVL_EXT2)) begin
          dec_ext  = 1'b1;
          dec_addr = {dm_ovl[1], core_addr[12:0]};
          dec_sel[`EMSD_CMS_DM] = 1'b1;
          dec_wait = wait_of(wait_ff[14:12], wmode);
        end
      end
      `EMSD_SP_IO: begin
        dec_ext  = 1'b1;
        dec_addr = {3'b000, core_addr[10:0]};
        dec_sel[`EMSD_CMS_IO] = 1'b1;
        case (core_addr[10:9])
          2'd0:    dec_wait = wait_of(wait_ff[2:0], wmode);
          2'd1:    dec_wait = wait_of(wait_ff[5:3], wmode);
          2'd2:    dec_wait = wait_of(wait_ff[8:6], wmode);
          default: dec_wait = wait_of(wait_ff[11:9], wmode);
        endcase
      end
      default: begin
        dec_ext  = 1'b1;
        dec_addr = core_addr;
        dec_sel[`EMSD_CMS_BM] = 1'b1;
        dec_wait = wait_ff[19:16];
      end
    endcase
    if (host_mode) begin
      dec_addr = {13'h0, dec_addr[0]};
    end
  end

  // control registers and on-chip space stay inside
  wire is_mmr  = (core_space == `EMSD_SP_DM) && (core_addr >= `EMSD_MMR_BASE);
  wire take    = core_req & (state_ff == ST_IDLE) & ~int_pend_ff & ~br_act;
  wire int_go  = take & ~dec_ext & ~dec_refuse & ~is_mmr;
  wire [6:0] ocm_addr = {core_space[0], core_addr[5:0]};
  wire [23:0] ocm_rdata;

  emsd_ocm u_ocm (
    .hclk     (hclk),
    .en       (int_go),
    .we       (core_we),
    .addr     (ocm_addr),
    .wdata    (core_wdata),
    .rdata_ff (ocm_rdata)
  );


  // selects shown on pins, composite follows enabled ones
  function [4:0] sel_pins;
    input [3:0] sel;
    input [3:0] en;
    input       bdis;
    reg   [3:0] shown;
    begin
      shown = sel;
      if (bdis) begin
        shown[`EMSD_CMS_BM] = 1'b0;
      end
      sel_pins = {|(sel & en), shown};
    end
  endfunction

  // ---------------- access engine ----------------
  reg [4:0] pins;

  always @* begin
    pins = sel_pins(dec_sel, composite_select_enables_ff, bms_dis_ff);
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff                  <= ST_IDLE;
      wcnt_ff                   <= 4'h0;
      space_ff                  <= 2'h0;
      we_ff                     <= 1'b0;
      int_pend_ff               <= 1'b0;
      core_ack_ff               <= 1'b0;
      core_refused_ff           <= 1'b0;
      core_rdata_ff             <= 24'h000000;
      core_busy_ff              <= 1'b0;
      ext_addr_ff               <= 14'h0000;
      ext_dout_ff               <= 24'h000000;
      ext_dout_oe_ff            <= 1'b0;
      ext_rd_n_ff               <= 1'b1;
      ext_wr_n_ff               <= 1'b1;
      program_mem_select_n_ff   <= 1'b1;
      data_mem_select_n_ff      <= 1'b1;
      byte_mem_select_n_ff      <= 1'b1;
      io_space_select_n_ff      <= 1'b1;
      composite_mem_select_n_ff <= 1'b1;
      mem_ctrl_oe_ff            <= 1'b1;
      bus_grant_n_ff            <= 1'b1;
    end else begin
      core_ack_ff     <= 1'b0;
      core_refused_ff <= 1'b0;
      int_pend_ff     <= 1'b0;
      if (int_pend_ff) begin
        core_ack_ff   <= 1'b1;
        core_rdata_ff <= (space_ff == `EMSD_SP_PM) ? ocm_rdata
                                                   : {8'h00, ocm_rdata[15:0]};
      end
      case (state_ff)
        ST_IDLE: begin
          core_busy_ff <= 1'b0;
          if (br_act && !int_pend_ff) begin
            state_ff       <= ST_GRANT;
            bus_grant_n_ff <= 1'b0;
            mem_ctrl_oe_ff <= 1'b0;
          end else if (take) begin
            space_ff <= core_space;
            we_ff    <= core_we;
            if (dec_refuse) begin
              core_refused_ff <= 1'b1;
              core_ack_ff     <= 1'b1;
            end else if (is_mmr) begin
              core_ack_ff   <= 1'b1;
              core_rdata_ff <= 24'h000000;
            end else if (dec_ext) begin
              state_ff                  <= ST_EXT;
              core_busy_ff              <= 1'b1;
              wcnt_ff                   <= dec_wait;
              ext_addr_ff               <= dec_addr;
              ext_dout_ff               <= (core_space == `EMSD_SP_PM) ? core_wdata
                                           : {8'h00, core_wdata[15:0]};
              ext_dout_oe_ff            <= core_we;
              ext_rd_n_ff               <= core_we;
              ext_wr_n_ff               <= ~core_we;
              program_mem_select_n_ff   <= ~pins[`EMSD_CMS_PM];
              data_mem_select_n_ff      <= ~pins[`EMSD_CMS_DM];
              byte_mem_select_n_ff      <= ~pins[`EMSD_CMS_BM];
              io_space_select_n_ff      <= ~pins[`EMSD_CMS_IO];
              composite_mem_select_n_ff <= ~pins[4];
            end else begin
              int_pend_ff <= 1'b1;
            end
          end
        end
        ST_EXT: begin
          // a pending bus request waits for the access in flight to end
          if (wcnt_ff == 4'h0) begin
            state_ff                  <= ST_IDLE;
            core_busy_ff              <= 1'b0;
            core_ack_ff               <= 1'b1;
            core_rdata_ff             <= (space_ff == `EMSD_SP_PM) ? din_s2_ff
                                         : {8'h00, din_s2_ff[15:0]};
            ext_dout_oe_ff            <= 1'b0;
            ext_rd_n_ff               <= 1'b1;
            ext_wr_n_ff               <= 1'b1;
            program_mem_select_n_ff   <= 1'b1;
            data_mem_select_n_ff      <= 1'b1;
            byte_mem_select_n_ff      <= 1'b1;
            io_space_select_n_ff      <= 1'b1;
            composite_mem_select_n_ff <= 1'b1;
          end else begin
            wcnt_ff <= wcnt_ff - 4'h1;
          end
        end
        ST_GRANT: begin
          core_busy_ff <= 1'b1;
          if (!br_act) begin
            state_ff       <= ST_IDLE;
            bus_grant_n_ff <= 1'b1;
            mem_ctrl_oe_ff <= 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: test/emsd_ext_mem.sv */
// behavioural external memory shared by every select of the block
`timescale 1ns/10ps
module emsd_ext_mem (
  // memory pins
  input  wire logic        hclk,
  input  wire logic [13:0] addr,
  input  wire logic [23:0] dout,
  input  wire logic        dout_oe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        sel_n,
  output logic      [23:0] din
);
  logic [23:0] mem [0:16383];
  logic [23:0] last;
  initial last = 24'h5a5a5a;
  always @(posedge hclk) begin
    if (!wr_n && !sel_n && dout_oe)
      mem[addr] <= dout;
    if (!rd_n && !sel_n)
      last <= mem[addr];
  end
  // released bus shows the inverse of the last value so stale data never matches
  assign din = (!rd_n && !sel_n) ? mem[addr] : ~last;
endmodule

/* File: test/emsd_properties.sv */
// checks on select, overlay address and wait length at the block's pins
`timescale 1ns/10ps
`include "emsd_defs.vh"
module emsd_props (
  // clock, reset and register bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // core and memory pins
  input wire logic [13:0] core_addr,
  input wire logic [13:0] ext_addr_ff,
  input wire logic        program_mem_select_n_ff,
  input wire logic        data_mem_select_n_ff,
  input wire logic        byte_mem_select_n_ff,
  input wire logic        io_space_select_n_ff,
  input wire logic        composite_mem_select_n_ff,
  input wire logic        host_mode_pin
);
  logic [7:0]  ovl_ff;
  logic [19:0] wait_ff;
  logic [4:0]  sysc_ff;
  logic        wpend_ff;
  logic [7:0]  waddr_ff;
  logic [4:0]  low_ff;
  logic [2:0]  iof_ff;
  wire         lo = !(data_mem_select_n_ff & io_space_select_n_ff);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  function automatic [4:0] wt(input [2:0] f);
    wt = wait_ff[15] ? {1'b0, f, 1'b1} : {2'b00, f};
  endfunction
  // shadow of register writes so the checks know the live settings
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovl_ff <= 8'h00;
      wait_ff <= 20'h00000;
      sysc_ff <= 5'h0b;
      wpend_ff <= 1'b0;
      waddr_ff <= 8'h00;
      low_ff <= 5'h00;
      iof_ff <= 3'h0;
    end else begin
      wpend_ff <= hsel & htrans[1] & hready & hwrite;
      waddr_ff <= haddr;
      low_ff <= lo ? low_ff + 5'h01 : 5'h00;
      if (!io_space_select_n_ff)
        iof_ff <= wait_ff[3 * ext_addr_ff[10:9] +: 3];
      if (wpend_ff && waddr_ff == `EMSD_OFS_OVLAY)
        ovl_ff <= hwdata[7:0];
      if (wpend_ff && waddr_ff == `EMSD_OFS_WAIT)
        wait_ff <= hwdata[19:0];
      if (wpend_ff && waddr_ff == `EMSD_OFS_SYSC)
        sysc_ff <= hwdata[4:0];
    end
  end
  a_cms_dm_tie: assert property (
    !data_mem_select_n_ff |-> composite_mem_select_n_ff == !sysc_ff[1])
    else $error("composite select not tied to data select");
  a_cms_io_tie: assert property (
    !io_space_select_n_ff |-> composite_mem_select_n_ff == !sysc_ff[3])
    else $error("composite select not tied to io select");
  a_pm_overlay_addr: assert property (
    !program_mem_select_n_ff |-> ext_addr_ff == {ovl_ff[3:0] == 4'h2, core_addr[12:0]})
    else $error("program overlay address wrong");
  a_dm_overlay_addr: assert property (
    !data_mem_select_n_ff && !host_mode_pin
    |-> ext_addr_ff == {ovl_ff[7:4] == 4'h2, core_addr[12:0]})
    else $error("data overlay address wrong");
  a_io_upper_bits: assert property (
    !io_space_select_n_ff |-> ext_addr_ff[13:11] == 3'b000)
    else $error("io access drives upper address bits");
  a_host_addr_a0: assert property (
    host_mode_pin && $past(host_mode_pin, 3) && !data_mem_select_n_ff
    |-> ext_addr_ff[13:1] == 13'h0000)
    else $error("host mode drives more than one address line");
  a_dm_wait_len: assert property (
    $rose(data_mem_select_n_ff) |-> low_ff == wt(wait_ff[14:12]) + 5'h01)
    else $error("data select length wrong");
  a_io_wait_len: assert property (
    $rose(io_space_select_n_ff) |-> low_ff == wt(iof_ff) + 5'h01)
    else $error("io select length wrong");
  a_bms_disable: assert property (
    !byte_mem_select_n_ff |-> !sysc_ff[4])
    else $error("byte select asserted while disabled");
endmodule
bind emsd_top emsd_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .core_addr, .ext_addr_ff, .program_mem_select_n_ff, .data_mem_select_n_ff,
  .byte_mem_select_n_ff, .io_space_select_n_ff, .composite_mem_select_n_ff, .host_mode_pin);

/* File: test/tb_top.sv */
// bench: register bus, random core accesses in every space, host mode and bus request
`timescale 1ns/10ps
`include "emsd_defs.vh"
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, core_req, core_we, bus_req_n, host_mode_pin, rf;
  logic [7:0]  haddr, ovl;
  logic [1:0]  htrans, core_space, sp;
  logic [2:0]  hsize;
  logic [31:0] hwdata, q, r, hrdata_ff;
  logic [13:0] core_addr, a, ext_addr_ff;
  logic [23:0] core_wdata, d, q24, core_rdata_ff, ext_dout_ff, ext_din;
  logic [19:0] ws;
  logic [4:0]  sc, seen;
  logic        hreadyout_ff, hresp_ff, core_ack_ff, core_refused_ff, core_busy_ff;
  logic        ext_dout_oe_ff, ext_rd_n_ff, ext_wr_n_ff, mem_ctrl_oe_ff, bus_grant_n_ff;
  logic        program_mem_select_n_ff, data_mem_select_n_ff, byte_mem_select_n_ff;
  logic        io_space_select_n_ff, composite_mem_select_n_ff;
  int          fails = 0;
  int          checks_done = 0;
  int          n, i;
  wire         hready = hreadyout_ff;
  wire         sel_n = program_mem_select_n_ff & data_mem_select_n_ff & byte_mem_select_n_ff
                       & io_space_select_n_ff & composite_mem_select_n_ff;
  emsd_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata_ff, .hreadyout_ff, .hresp_ff, .core_req, .core_space, .core_addr, .core_we,
    .core_wdata, .core_ack_ff, .core_refused_ff, .core_rdata_ff, .core_busy_ff, .ext_addr_ff,
    .ext_dout_ff, .ext_dout_oe_ff, .ext_din, .ext_rd_n_ff, .ext_wr_n_ff,
    .program_mem_select_n_ff, .data_mem_select_n_ff, .byte_mem_select_n_ff,
    .io_space_select_n_ff, .composite_mem_select_n_ff, .mem_ctrl_oe_ff, .bus_req_n,
    .bus_grant_n_ff, .host_mode_pin);
  emsd_ext_mem u_mem (.hclk, .addr(ext_addr_ff), .dout(ext_dout_ff), .dout_oe(ext_dout_oe_ff),
    .rd_n(ext_rd_n_ff), .wr_n(ext_wr_n_ff), .sel_n, .din(ext_din));
  always #4 hclk = ~hclk;
  always @(posedge hclk) seen <= seen | ~{composite_mem_select_n_ff, io_space_select_n_ff,
    byte_mem_select_n_ff, data_mem_select_n_ff, program_mem_select_n_ff};
  function automatic [31:0] lfsr(input [31:0] s);
    for (int k = 0; k < 32; k++)
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  function automatic [4:0] exp_sel(input [1:0] p, input [13:0] x);
    logic [3:0] one;
    logic       ext;
    ext = p[1] | (p == 2'h0 && x[13] && (ovl[3:0] == 4'h1 || ovl[3:0] == 4'h2))
        | (p == 2'h1 && !x[13] && (ovl[7:4] == 4'h1 || ovl[7:4] == 4'h2));
    one = ext ? 4'h1 << {p[1], p[1] ^ p[0]} : 4'h0;
    return {|(one & sc[3:0]), one & ~{1'b0, sc[4], 2'b00}};
  endfunction
  function automatic int exp_lat(input [1:0] p, input [13:0] x);
    int f;
    f = (p == 2'h1) ? ws[14:12] : ws[3 * x[10:9] +: 3];
    if (p == 2'h3)
      return ws[19:16] + 2;
    return (ws[15] ? 2 * f + 1 : f) + 2;
  endfunction
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ahb(input [7:0] ad, input w, input [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata_ff;
    hsel <= 1'b0;
  endtask
  // request held until ack is seen, dropped in the ack cycle
  task automatic acc(input [1:0] p, input [13:0] x, input w, input [23:0] wd);
    @(posedge hclk);
    core_space <= p;
    core_addr <= x;
    core_we <= w;
    core_wdata <= wd;
    core_req <= 1'b1;
    #1 seen = 5'h00;
    n = 0;
    do begin
      @(posedge hclk);
      #1 n++;
    end while (core_ack_ff !== 1'b1 && n < 100);
    if (core_ack_ff !== 1'b1)
      fails++;
    q24 = core_rdata_ff;
    rf = core_refused_ff;
    core_req <= 1'b0;
  endtask
  initial begin
    #400000;
    fails++;
    close_out();
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, core_req, core_we, host_mode_pin} = 5'h00;
    bus_req_n = 1'b1;
    {haddr, htrans, core_space, hwdata, core_addr, core_wdata, seen} = '0;
    hsize = 3'h2;
    r = 32'hbc46;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(`EMSD_OFS_SYSC, 1'b0, 32'h0);
    chk("enables at reset", q, 32'h0000000b);
    ahb(8'h10, 1'b0, 32'h0);
    chk("unmapped read", q, 32'h0);
    chk("bus response", {hreadyout_ff, hresp_ff}, 2'b10);
    for (i = 0; i < 48; i++) begin
      r = lfsr(r);
      ovl = {2'b00, r[5:4], 2'b00, r[1:0]};
      sp = r[22:21];
      ws = r[19:0] | 20'h22492;
      if (sp == 2'h3)
        ws[15] = 1'b0;
      sc = r[28:24];
      ahb(`EMSD_OFS_OVLAY, 1'b1, {24'h0, ovl});
      ahb(`EMSD_OFS_WAIT, 1'b1, {12'h0, ws});
      ahb(`EMSD_OFS_SYSC, 1'b1, {27'h0, sc});
      ahb(`EMSD_OFS_WAIT, 1'b0, 32'h0);
      chk("wait register", q, {12'h0, ws});
      r = lfsr(r);
      d = r[31:8];
      a = (sp == 2'h2) ? {3'b000, r[10:0]} : r[13:0];
      if (i % 4 == 0 && sp == 2'h1)
        a = {9'h1ff, r[4:0]};
      acc(sp, a, 1'b1, d);
      acc(sp, a, 1'b0, 24'h0);
      chk("selects", seen, exp_sel(sp, a));
      if (sp != 2'h3)
        chk("read data", q24, (sp == 2'h1 && a >= 14'h3fe0) ? 24'h0
            : d & {{8{sp == 2'h0}}, 16'hffff});
      if (exp_sel(sp, a) == 5'h00 && sp != 2'h3)
        chk("on-chip latency", n, (sp == 2'h1 && a >= 14'h3fe0) ? 1 : 2);
      else if (sp != 2'h0)
        chk("wait length", n, exp_lat(sp, a));
    end
    @(posedge hclk);
    host_mode_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(`EMSD_OFS_OVLAY, 1'b1, 32'h11);
    acc(2'h0, 14'h2005, 1'b0, 24'h0);
    chk("host program access", {rf, seen}, 6'h20);
    acc(2'h1, 14'h0003, 1'b1, 24'h00abcd);
    chk("host address", ext_addr_ff, 14'h0001);
    @(posedge hclk);
    host_mode_pin <= 1'b0;
    bus_req_n <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      #1 n++;
    end while (bus_grant_n_ff !== 1'b0 && n < 20);
    chk("granted pins", {bus_grant_n_ff, mem_ctrl_oe_ff, composite_mem_select_n_ff},
        3'b001);
    ahb(`EMSD_OFS_STAT, 1'b0, 32'h0);
    chk("status in grant", q, 32'h00000006);
    bus_req_n <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("released pins", {bus_grant_n_ff, mem_ctrl_oe_ff}, 2'b11);
    close_out();
  end
endmodule
